// ### rtl/adcr_top.sv
// top: APB register file, pin routing and result formatting of the converter
//
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/1ns
module adcr_top
  import adcr_pkg::*;
#(
  parameter int NUM_CHANNELS = 8
) (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // converter analog front end
  input wire logic [11:0] conv_data_in,
  output logic conv_sample,
  output logic conv_power_en,
  output logic [1:0] conv_mux_sel,
  output logic [2:0] conv_ext_chan,
  output logic conv_ext_connect,
  output logic [1:0] conv_ref_sel,
  // pin routing
  output logic [7:0] analog_input_pins_en,
  output logic [7:0] pin_digital_en,
  output logic [7:0] pin_pullhigh_allow
);
  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic start_reg;
  logic enable_reg;
  logic align_reg;
  logic [3:0] chan_reg;
  logic [7:0] ctrl2_reg;
  logic [7:0] pin_en_reg;
  logic [11:0] result_reg;
  logic [11:0] sync1_reg;
  logic [11:0] sync2_reg;
  logic [31:0] prdata_reg;
  logic start_arm_reg;

  adcr_conv_if cv ();

  adcr_conv_seq u_seq (
    .pclk(pclk),
    .presetn(presetn),
    .cv(cv)
  );

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  logic wr_en;
  logic rd_en;
  logic hit_lo;
  logic hit_hi;
  logic hit_c0;
  logic hit_c1;
  logic hit_pe;
  logic hit_any;
  logic [7:0] wbyte;
  logic [7:0] pin_mask;

  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !pwrite;
  assign hit_lo = (paddr == ADCR_OFF_RESULT_LOW);
  assign hit_hi = (paddr == ADCR_OFF_RESULT_HIGH);
  assign hit_c0 = (paddr == ADCR_OFF_CTRL_PRIMARY);
  assign hit_c1 = (paddr == ADCR_OFF_CTRL_SECONDARY);
  assign hit_pe = (paddr == ADCR_OFF_PIN_ENABLES);
  assign hit_any = hit_lo | hit_hi | hit_c0 | hit_c1 | hit_pe;
  assign wbyte = pwdata[7:0];
  // unused channel enables on the six-channel variant stay zero
  assign pin_mask = 8'hff >> (8 - NUM_CHANNELS);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit_any;

  // ----------------------------------------
  // result formatting
  // ----------------------------------------
  logic [7:0] res_low;
  logic [7:0] res_high;
  logic [7:0] ctrl1_view;

  assign res_high = align_reg ? {4'h0, result_reg[11:8]}
                              : result_reg[11:4];
  assign res_low = align_reg ? result_reg[7:0]
                             : {result_reg[3:0], 4'h0};
  // busy stays up through the done cycle, so it falls only once the
  // result load has landed
  logic busy_view;
  assign busy_view = cv.busy | cv.done;
  assign ctrl1_view = {start_reg, busy_view, enable_reg, align_reg, chan_reg};

  logic [7:0] rd_byte;
  assign rd_byte = hit_lo ? res_low :
                   hit_hi ? res_high :
                   hit_c0 ? ctrl1_view :
                   hit_c1 ? ctrl2_reg :
                   hit_pe ? pin_en_reg : 8'h00;
  assign prdata = prdata_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (rd_en && !penable) begin
      prdata_reg <= {24'h00_0000, rd_byte};
    end
  end

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  // result registers take no bus write at all
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_reg <= ADCR_RST_CTRL_PRIMARY[ADCR_BIT_START];
      enable_reg <= ADCR_RST_CTRL_PRIMARY[ADCR_BIT_ENABLE];
      align_reg <= ADCR_RST_CTRL_PRIMARY[ADCR_BIT_ALIGN];
      chan_reg <= ADCR_RST_CTRL_PRIMARY[3:0];
      ctrl2_reg <= ADCR_RST_CTRL_SECONDARY;
      pin_en_reg <= ADCR_RST_PIN_ENABLES;
    end else if (wr_en) begin
      if (hit_c0) begin
        start_reg <= wbyte[ADCR_BIT_START];
        enable_reg <= wbyte[ADCR_BIT_ENABLE];
        align_reg <= wbyte[ADCR_BIT_ALIGN];
        chan_reg <= wbyte[ADCR_CHAN_LSB +: 4];
      end
      if (hit_c1) begin
        ctrl2_reg <= wbyte;
      end
      if (hit_pe) begin
        pin_en_reg <= wbyte & pin_mask;
      end
    end
  end

  // ----------------------------------------
  // start sequence
  // ----------------------------------------
  // the start bit must rise and then fall; the fall launches the conversion
  logic start_fire;
  assign start_fire = start_arm_reg && !start_reg && enable_reg;
  assign cv.start = start_fire;
  assign cv.clk_div_sel = ctrl2_reg[ADCR_CLK_LSB +: 3];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_arm_reg <= 1'b0;
    end else if (start_reg) begin
      start_arm_reg <= 1'b1;
    end else begin
      start_arm_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // result capture
  // ----------------------------------------
  // converter data is asynchronous to pclk; it is stable by the end of
  // conversion, so a two-stage sync is enough and costs two cycles only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= 12'h000;
      sync2_reg <= 12'h000;
      result_reg <= 12'h000;
    end else begin
      sync1_reg <= conv_data_in;
      sync2_reg <= sync1_reg;
      // only a finished conversion loads; disabling never clears it
      if (cv.done) begin
        result_reg <= sync2_reg;
      end
    end
  end

  // ----------------------------------------
  // analog selection
  // ----------------------------------------
  adcr_src_t src;
  logic src_ext;
  assign src = adcr_src_t'(ctrl2_reg[ADCR_SRC_LSB +: 3]);
  assign src_ext = (src == ADCR_SRC_EXT0) || (src == ADCR_SRC_EXT5) ||
                   (src == ADCR_SRC_EXT6) || (src == ADCR_SRC_EXT7);
  // an external pin joins only when its channel code is in range and the
  // pin is enabled, so an internal signal never shorts to a pin
  assign conv_ext_connect = src_ext && !chan_reg[3] &&
                            pin_en_reg[chan_reg[2:0]];
  assign conv_ext_chan = chan_reg[2:0];
  assign conv_mux_sel = src_ext ? ADCR_MUX_EXT :
                        (src == ADCR_SRC_BANDGAP) ? ADCR_MUX_BANDGAP :
                        (src == ADCR_SRC_AMP) ? ADCR_MUX_AMP :
                        ADCR_MUX_GND;
  assign conv_ref_sel = ctrl2_reg[ADCR_REF_LSB +: 2];
  assign conv_power_en = enable_reg;
  assign conv_sample = cv.sample_tick;

  // ----------------------------------------
  // pin routing
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_pin
      assign analog_input_pins_en[gi] = pin_en_reg[gi];
      assign pin_digital_en[gi] = !pin_en_reg[gi];
      assign pin_pullhigh_allow[gi] = !pin_en_reg[gi];
    end
  endgenerate
endmodule

// ### rtl/adcr_pkg.sv
// package: register map, field positions and reset values of the converter block
package adcr_pkg;
  // ----------------------------------------
  // register byte addresses
  // ----------------------------------------
  localparam logic [7:0] ADCR_OFF_RESULT_LOW = 8'h00;
  localparam logic [7:0] ADCR_OFF_RESULT_HIGH = 8'h04;
  localparam logic [7:0] ADCR_OFF_CTRL_PRIMARY = 8'h08;
  localparam logic [7:0] ADCR_OFF_CTRL_SECONDARY = 8'h0c;
  localparam logic [7:0] ADCR_OFF_PIN_ENABLES = 8'h10;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] ADCR_RST_CTRL_PRIMARY = 8'h00;
  localparam logic [7:0] ADCR_RST_CTRL_SECONDARY = 8'h00;
  localparam logic [7:0] ADCR_RST_PIN_ENABLES = 8'h00;
  // ----------------------------------------
  // primary control field positions
  // ----------------------------------------
  localparam int ADCR_BIT_START = 7;
  localparam int ADCR_BIT_BUSY = 6;
  localparam int ADCR_BIT_ENABLE = 5;
  localparam int ADCR_BIT_ALIGN = 4;
  localparam int ADCR_CHAN_LSB = 0;
  // ----------------------------------------
  // secondary control field positions
  // ----------------------------------------
  localparam int ADCR_SRC_LSB = 5;
  localparam int ADCR_REF_LSB = 3;
  localparam int ADCR_CLK_LSB = 0;
  // ----------------------------------------
  // conversion timing
  // ----------------------------------------
  localparam int ADCR_RESULT_BITS = 12;
  localparam int ADCR_CONV_TICKS = 16;
  // ----------------------------------------
  // input source codes
  // ----------------------------------------
  typedef enum logic [2:0] {
    ADCR_SRC_EXT0 = 3'h0,
    ADCR_SRC_BANDGAP = 3'h1,
    ADCR_SRC_GND0 = 3'h2,
    ADCR_SRC_AMP = 3'h3,
    ADCR_SRC_GND1 = 3'h4,
    ADCR_SRC_EXT5 = 3'h5,
    ADCR_SRC_EXT6 = 3'h6,
    ADCR_SRC_EXT7 = 3'h7
  } adcr_src_t;
  // analog mux selection driven to the converter
  typedef enum logic [1:0] {
    ADCR_MUX_EXT = 2'h0,
    ADCR_MUX_BANDGAP = 2'h1,
    ADCR_MUX_AMP = 2'h2,
    ADCR_MUX_GND = 2'h3
  } adcr_mux_t;
endpackage

// ### rtl/adcr_conv_if.sv
// interface: handshake between the control logic and the conversion sequencer
`timescale 1ns/1ns
interface adcr_conv_if;
  logic start;
  logic [2:0] clk_div_sel;
  logic busy;
  logic done;
  logic sample_tick;
  modport ctrl (output start, output clk_div_sel, input busy, input done,
    input sample_tick);
  modport seq (input start, input clk_div_sel, output busy, output done,
    output sample_tick);
endinterface

// ### rtl/adcr_conv_seq.sv
// conversion sequencer: clock divider and conversion timing
`timescale 1ns/1ns
module adcr_conv_seq
  import adcr_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control side
  adcr_conv_if.seq cv
);
  // ----------------------------------------
  // divider
  // ----------------------------------------
  logic [6:0] div_cnt_reg;
  logic [6:0] div_max;
  logic [4:0] tick_cnt_reg;
  logic busy_reg;
  logic done_reg;
  logic tick;

  // code 110 divides by 32 like 101
  assign div_max = (cv.clk_div_sel == 3'h7) ? 7'h7f :
                   (cv.clk_div_sel == 3'h6) ? 7'h1f :
                   7'((8'h01 << cv.clk_div_sel) - 8'h01);
  assign tick = busy_reg && (div_cnt_reg >= div_max);
  assign cv.busy = busy_reg;
  assign cv.done = done_reg;
  assign cv.sample_tick = tick;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_reg <= 7'h00;
      tick_cnt_reg <= 5'h00;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (!busy_reg) begin
        div_cnt_reg <= 7'h00;
        tick_cnt_reg <= 5'h00;
        // one converter: a start while busy is ignored
        if (cv.start) begin
          busy_reg <= 1'b1;
        end
      end else if (tick) begin
        div_cnt_reg <= 7'h00;
        if (tick_cnt_reg == 5'(ADCR_CONV_TICKS - 1)) begin
          busy_reg <= 1'b0;
          done_reg <= 1'b1;
        end else begin
          tick_cnt_reg <= tick_cnt_reg + 5'h01;
        end
      end else begin
        div_cnt_reg <= div_cnt_reg + 7'h01;
      end
    end
  end
endmodule

// ### test/adcr_top_properties.sv
// checker: port-level assertions for the converter register block
`timescale 1ns/1ns
module adcr_top_chk
  import adcr_pkg::*;
#(
  parameter int NUM_CHANNELS = 8
) (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // converter and pins
  input wire logic conv_sample,
  input wire logic [1:0] conv_mux_sel,
  input wire logic [2:0] conv_ext_chan,
  input wire logic conv_ext_connect,
  input wire logic [7:0] analog_input_pins_en,
  input wire logic [7:0] pin_digital_en,
  input wire logic [7:0] pin_pullhigh_allow
);
  // ----------------------------------------
  // register mirrors
  // ----------------------------------------
  logic [7:0] a_m;
  logic [7:0] s_m;
  logic [7:0] p_m;
  wire wr = psel && penable && pwrite;
  wire rd_acc = psel && penable && !pwrite;
  wire [2:0] src = s_m[7:5];
  wire [1:0] mux_x = (src == 3'h1) ? 2'h1 : (src == 3'h3) ? 2'h2 :
    (src == 3'h2 || src == 3'h4) ? 2'h3 : 2'h0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_m <= 8'h00;
      s_m <= 8'h00;
      p_m <= 8'h00;
    end else if (wr) begin
      if (paddr == ADCR_OFF_CTRL_PRIMARY) a_m <= pwdata[7:0];
      if (paddr == ADCR_OFF_CTRL_SECONDARY) s_m <= pwdata[7:0];
      if (paddr == ADCR_OFF_PIN_ENABLES)
        p_m <= (NUM_CHANNELS == 6) ? (pwdata[7:0] & 8'h3f) : pwdata[7:0];
    end
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  pin_dig_a:
    assert property (pin_digital_en == ~analog_input_pins_en)
      else $error("digital enable not inverse of analog enable");
  pull_off_a:
    assert property (pin_pullhigh_allow == ~analog_input_pins_en)
      else $error("pull-high kept on analog pin");
  pin_route_a:
    assert property (analog_input_pins_en == p_m)
      else $error("pin routing differs from written enables");
  mux_map_a:
    assert property (conv_mux_sel == mux_x)
      else $error("source code mapped to wrong signal");
  one_src_a:
    assert property (conv_ext_connect == (mux_x == 2'h0 && !a_m[3] &&
      p_m[a_m[2:0]]) && conv_ext_chan == a_m[2:0])
      else $error("external connect wrong for source and channel");
  align_hi_a:
    assert property (rd_acc && paddr == ADCR_OFF_RESULT_HIGH && a_m[4]
      |-> prdata[31:4] == 28'h0)
      else $error("unused high result bits not zero");
  align_lo_a:
    assert property (rd_acc && paddr == ADCR_OFF_RESULT_LOW && !a_m[4]
      |-> prdata[31:8] == 24'h0 && prdata[3:0] == 4'h0)
      else $error("unused low result bits not zero");
  div_gap_a:
    assert property (conv_sample && s_m[2:0] == 3'h3 |=> !conv_sample [*7])
      else $error("conversion tick spacing wrong for divide by 8");
  c_conn: cover property (conv_ext_connect);
  c_tick: cover property (conv_sample && s_m[2:0] == 3'h7);
  c_read: cover property (rd_acc && paddr == ADCR_OFF_RESULT_HIGH && a_m[4]);
endmodule

bind adcr_top adcr_top_chk #(.NUM_CHANNELS(NUM_CHANNELS)) chk_i (.*);

// ### test/adcr_top_tb.sv
// testbench: register, routing and conversion checks of the converter
`timescale 1ns/1ns
module adcr_top_tb
  import adcr_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr, analog_input_pins_en, pin_digital_en;
  logic [7:0] pin_pullhigh_allow;
  logic [31:0] pwdata, prdata, rd;
  logic conv_sample, conv_power_en, conv_ext_connect;
  logic [11:0] conv_data_in;
  logic [1:0] conv_mux_sel, conv_ref_sel;
  logic [2:0] conv_ext_chan;
  int bad_count = 0;
  int cmp_count = 0;
  int res, pins;
  adcr_top #(.NUM_CHANNELS(8)) uut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .conv_data_in(conv_data_in), .conv_sample(conv_sample),
    .conv_power_en(conv_power_en), .conv_mux_sel(conv_mux_sel),
    .conv_ext_chan(conv_ext_chan), .conv_ext_connect(conv_ext_connect),
    .conv_ref_sel(conv_ref_sel), .analog_input_pins_en(analog_input_pins_en),
    .pin_digital_en(pin_digital_en), .pin_pullhigh_allow(pin_pullhigh_allow));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // ----------------------------------------
  // tasks and model
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] s, input int e);
    cmp_count++;
    if (s !== 32'(e)) begin
      bad_count++;
      $display("[FAIL] %s exp %h seen %h", nm, 32'(e), s);
    end
  endtask
  // one full transfer; the idle edge at the end drops psel low for one cycle before the next transfer
  task automatic apb(input logic w, input logic [7:0] a, input int d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= 32'(d);
    @(posedge pclk);
    penable <= 1'b1;
    // wait states end only on pready; a hang is left to the watchdog
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  function automatic int mux_of(int s);
    if (s == 1) return 1;
    if (s == 3) return 2;
    if (s == 2 || s == 4) return 3;
    return 0;
  endfunction
  task automatic check_result(input int al);
    apb(1'b1, ADCR_OFF_CTRL_PRIMARY, 32'h20 | (al << 4));
    apb(1'b0, ADCR_OFF_RESULT_LOW, 0);
    chk("result low", rd, al ? res & 255 : (res & 15) << 4);
    apb(1'b0, ADCR_OFF_RESULT_HIGH, 0);
    chk("result high", rd, al ? res >> 8 : res >> 4);
  endtask
  task automatic convert(input int c);
    int t = 0;
    int d;
    d = (c < 6) ? (1 << c) : (c == 6) ? 32 : 128;
    res = $urandom_range(0, 4095);
    conv_data_in <= res[11:0];
    apb(1'b1, ADCR_OFF_CTRL_SECONDARY, c);
    apb(1'b1, ADCR_OFF_CTRL_PRIMARY, 32'ha0);
    apb(1'b1, ADCR_OFF_CTRL_PRIMARY, 32'h20);
    apb(1'b0, ADCR_OFF_CTRL_PRIMARY, 0);
    chk("busy set", rd[6], 1);
    // a second start while busy must not restart the single converter;
    // the two writes take as long as two polls
    apb(1'b1, ADCR_OFF_CTRL_PRIMARY, 32'ha0);
    apb(1'b1, ADCR_OFF_CTRL_PRIMARY, 32'h20);
    t = 2;
    while (rd[6] === 1'b1 && t < 3000) begin
      apb(1'b0, ADCR_OFF_CTRL_PRIMARY, 0);
      t++;
    end
    chk("busy span", 3 * t + 5 >= 16 * d && 3 * t <= 16 * d + 8, 1);
    check_result(0);
    check_result(1);
  endtask
  task automatic finish_test;
    if (bad_count == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(91087));
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, conv_data_in} = '0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ADCR_OFF_CTRL_PRIMARY, 0);
    chk("primary reset", rd, ADCR_RST_CTRL_PRIMARY);
    apb(1'b0, ADCR_OFF_CTRL_SECONDARY, 0);
    chk("secondary reset", rd, ADCR_RST_CTRL_SECONDARY);
    chk("pull-high at reset", pin_pullhigh_allow, 255);
    apb(1'b1, 8'h20, 255);
    chk("unmapped err", err, 1);
    // pins 0 and 2 carry the channels used below, enabled before selection
    pins = $urandom_range(0, 255) | 5;
    apb(1'b1, ADCR_OFF_PIN_ENABLES, pins);
    apb(1'b0, ADCR_OFF_PIN_ENABLES, 0);
    chk("pin enables", rd, pins);
    chk("pin digital", pin_digital_en, ~pins & 255);
    chk("pin pull-high", pin_pullhigh_allow, ~pins & 255);
    apb(1'b1, ADCR_OFF_CTRL_PRIMARY, 32'h02);
    for (int s = 0; s < 8; s++) begin
      // internal sources only after every pin enable is cleared
      apb(1'b1, ADCR_OFF_PIN_ENABLES, mux_of(s) ? 0 : pins);
      apb(1'b1, ADCR_OFF_CTRL_SECONDARY, (s << 5) | ((s & 3) << 3));
      chk("mux select", conv_mux_sel, mux_of(s));
      chk("ext connect", conv_ext_connect, mux_of(s) == 0);
      chk("ref select", conv_ref_sel, s & 3);
    end
    for (int c = 0; c < 8; c++) convert(c);
    apb(1'b1, ADCR_OFF_RESULT_LOW, 255);
    apb(1'b1, ADCR_OFF_RESULT_HIGH, 255);
    check_result(1);
    apb(1'b1, ADCR_OFF_CTRL_PRIMARY, 32'h10);
    chk("power off", conv_power_en, 0);
    apb(1'b0, ADCR_OFF_RESULT_LOW, 0);
    chk("kept when off", rd, res & 255);
    apb(1'b1, ADCR_OFF_CTRL_PRIMARY, 32'h90);
    apb(1'b1, ADCR_OFF_CTRL_PRIMARY, 32'h10);
    apb(1'b0, ADCR_OFF_CTRL_PRIMARY, 0);
    chk("no start when off", rd[6], 0);
    finish_test;
  end
  initial begin
    #200000;
    bad_count++;
    finish_test;
  end
endmodule
